// >>> hw/fepc_consts.svh
// Constants for the flash erase and page program command block
`ifndef FEPC_CONSTS_SVH
`define FEPC_CONSTS_SVH
// Opcodes
`define FEPC_OP_WRITE_UNLOCK 8'h06
`define FEPC_OP_SECTOR_ERASE 8'h20
`define FEPC_OP_HALF_BLOCK   8'h52
`define FEPC_OP_BLOCK_ERASE  8'hD8
`define FEPC_OP_CHIP_ERASE_A 8'h60
`define FEPC_OP_CHIP_ERASE_B 8'hC7
`define FEPC_OP_PAGE_WRITE   8'h02
// Frame lengths in bytes
`define FEPC_HDR_OPC_ONLY    3'd1
`define FEPC_HDR_WITH_ADDR   3'd4
`define FEPC_PAGE_BYTES      9'd256
// Address alignment masks
`define FEPC_SECTOR_MASK     24'hFF_F000
`define FEPC_HALF_MASK       24'hFF_8000
`define FEPC_BLOCK_MASK      24'hFF_0000
`define FEPC_PAGE_MASK       24'hFF_FF00
// Clock rate and self-timed durations (microseconds)
`define FEPC_MCLK_MHZ        25
`define FEPC_SECTOR_ERASE_US 30000
`define FEPC_HALF_ERASE_US   120000
`define FEPC_BLOCK_ERASE_US  150000
`define FEPC_ARRAY_ERASE_US  1000000
`define FEPC_PAGE_WRITE_US   800
// Protection geometry: 64K blocks in the array
`define FEPC_NUM_BLOCKS      7'd32
`endif

// >>> hw/fepc_pkg.sv
// Types for the flash erase and page program command block
`default_nettype none
package fepc_pkg;
    // Kind of array operation handed to the core
    typedef enum logic [2:0] {
        FEPC_K_SECTOR, FEPC_K_HALF, FEPC_K_BLOCK, FEPC_K_CHIP, FEPC_K_PAGE
    } fepc_kind_e;
    // Sequencer state
    typedef enum logic {FEPC_ST_IDLE, FEPC_ST_BUSY} fepc_state_e;
    // Request to the array core
    typedef struct packed {
        logic        valid;
        fepc_kind_e  kind;
        logic [23:0] addr;
    } fepc_req_s;
    // Link-side frame state
    typedef struct packed {
        logic             quad_s1;
        logic             quad_s2;
        logic [7:0]       sh;
        logic [3:0]       bpos;
        logic [2:0]       hdr;
        logic [7:0]       opc;
        logic [23:0]      addr;
        logic [8:0]       nbytes;
        logic [7:0]       wptr;
        logic [255:0]     mask;
        logic [255:0][7:0] buff;
    } fepc_link_s;
    // System-side sequencer state
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_s3;
        fepc_state_e st;
        logic        write_unlock_latch;
        logic [31:0] timer;
        fepc_req_s   req;
        logic        rej;
        logic [7:0]  rd;
        logic        rdv;
    } fepc_sys_s;
endpackage : fepc_pkg
`default_nettype wire

// >>> hw/fepc_top.sv
// Erase family and page program command sequencer of a serial flash
`include "fepc_consts.svh"
`default_nettype none
module fepc_top
    import fepc_pkg::*;
#(
    parameter int unsigned SE_CYC = `FEPC_SECTOR_ERASE_US * `FEPC_MCLK_MHZ,
    parameter int unsigned HB_CYC = `FEPC_HALF_ERASE_US * `FEPC_MCLK_MHZ,
    parameter int unsigned BE_CYC = `FEPC_BLOCK_ERASE_US * `FEPC_MCLK_MHZ,
    parameter int unsigned CE_CYC = `FEPC_ARRAY_ERASE_US * `FEPC_MCLK_MHZ,
    parameter int unsigned PP_CYC = `FEPC_PAGE_WRITE_US * `FEPC_MCLK_MHZ
) (
    input  wire logic       I_MCLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_SCK,
    input  wire logic       I_CS_N,
    input  wire logic [3:0] I_SIO,
    output logic      [3:0] O_SIO,
    output logic      [3:0] O_SIO_OE,
    input  wire logic       I_QUAD_MODE,
    input  wire logic [4:0] I_PROTECT_SEL,
    input  wire logic [7:0] I_BUF_IDX,
    output logic      [7:0] O_BUF_BYTE,
    output logic            O_BUF_VALID,
    output fepc_req_s       O_ARRAY_REQ,
    output logic            O_OP_IN_PROGRESS,
    output logic            O_WRITE_UNLOCK_LATCH,
    output logic            O_CMD_REJECT
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: frame capture on the serial clock
    ////////////////////////////////////////////////////////////////////////////

    fepc_link_s lq;          // Link state
    fepc_link_s ld;          // Link next state
    logic       armed_q;     // High from chip select high to first edge

    // Frame start marker; chip select high re-arms it, first edge clears it.
    // The clock stops outside frames, so counters cannot be cleared there.
    always_ff @(posedge I_SCK or posedge I_CS_N) begin
        if (I_CS_N) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    // Shift in bits, split opcode, address and page data
    always_comb begin
        logic [3:0] bp0;
        logic [2:0] hdr0;
        logic [8:0] nb0;
        logic [7:0] sh;
        logic [3:0] bp;
        sh   = 8'h00;
        bp   = 4'd0;
        bp0  = armed_q ? 4'd0 : lq.bpos;
        hdr0 = armed_q ? 3'd0 : lq.hdr;
        nb0  = armed_q ? 9'd0 : lq.nbytes;
        ld   = lq;
        // Fresh frame: forget which page bytes were written
        if (armed_q) begin
            ld.mask = '0;
        end
        // Mode level crosses into this domain through two flops
        ld.quad_s1 = I_QUAD_MODE;
        ld.quad_s2 = lq.quad_s1;
        if (lq.quad_s2) begin
            sh = {lq.sh[3:0], I_SIO};
            bp = bp0 + 4'd4;
        end else begin
            // only the first data line is used
            sh = {lq.sh[6:0], I_SIO[0]};
            bp = bp0 + 4'd1;
        end
        ld.sh     = sh;
        ld.bpos   = bp;
        ld.hdr    = hdr0;
        ld.nbytes = nb0;
        // Byte complete
        if (bp == 4'd8) begin
            ld.bpos = 4'd0;
            case (hdr0)
                3'd0: begin
                    ld.opc = sh;
                end
                3'd1: begin
                    ld.addr[23:16] = sh;
                end
                3'd2: begin
                    ld.addr[15:8] = sh;
                end
                3'd3: begin
                    ld.addr[7:0] = sh;
                    ld.wptr      = sh;
                end
                default: begin
                    // eight-bit pointer wraps inside the page
                    ld.buff[lq.wptr] = sh;
                    // mark only the bytes really sent
                    ld.mask[lq.wptr] = 1'b1;
                    ld.wptr          = lq.wptr + 8'd1;
                    if (nb0 != `FEPC_PAGE_BYTES) begin
                        ld.nbytes = nb0 + 9'd1;
                    end
                end
            endcase
            if (hdr0 != `FEPC_HDR_WITH_ADDR) begin
                ld.hdr = hdr0 + 3'd1;
            end
        end
    end

    // Link state register
    always_ff @(posedge I_SCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: command decode and self-timed cycle
    ////////////////////////////////////////////////////////////////////////////

    fepc_sys_s q;            // System state
    fepc_sys_s d;            // System next state
    logic      cs_rise;      // Frame ended, link state now stable
    logic      ok_opc;       // Exactly one byte clocked
    logic      ok_addr;      // Exactly four bytes clocked
    logic      ok_page;      // Header plus whole data bytes
    logic      is_erase;     // Address-carrying erase opcode
    logic      is_chip;      // Chip erase opcode
    logic      prot_hit;     // Target overlaps protected area
    fepc_kind_e kind;        // Decoded operation

    // Protection: low three bits size a region of 64K blocks, bit 3
    // moves it to the bottom, bit 4 with any nonzero size protects everything.
    function automatic logic prot_f(input logic [4:0] bp,
                                    input logic [4:0] blk);
        logic [6:0] sz;
        sz = 7'd1 << (bp[2:0] - 3'd1);
        if (bp[2:0] == 3'd0) begin
            return 1'b0;
        end else if (bp[4] || sz >= `FEPC_NUM_BLOCKS) begin
            return 1'b1;
        end else if (bp[3]) begin
            return {2'b00, blk} < sz;
        end
        return {2'b00, blk} >= (`FEPC_NUM_BLOCKS - sz);
    endfunction : prot_f

    // Duration of each cycle, less one for the terminal count
    function automatic logic [31:0] dur_f(input fepc_kind_e k);
        case (k)
            FEPC_K_SECTOR: return 32'(SE_CYC - 1);
            FEPC_K_HALF:   return 32'(HB_CYC - 1);
            FEPC_K_BLOCK:  return 32'(BE_CYC - 1);
            FEPC_K_CHIP:   return 32'(CE_CYC - 1);
            default:       return 32'(PP_CYC - 1);
        endcase
    endfunction : dur_f

    // Framing checks on the frozen link counters
    assign cs_rise  = q.cs_s2 & ~q.cs_s3;
    assign ok_opc   = lq.hdr == `FEPC_HDR_OPC_ONLY && lq.bpos == 4'd0;
    assign ok_addr  = lq.hdr == `FEPC_HDR_WITH_ADDR && lq.bpos == 4'd0
                      && lq.nbytes == 9'd0;
    assign ok_page  = lq.hdr == `FEPC_HDR_WITH_ADDR && lq.bpos == 4'd0
                      && lq.nbytes != 9'd0;
    assign is_chip  = lq.opc == `FEPC_OP_CHIP_ERASE_A
                      || lq.opc == `FEPC_OP_CHIP_ERASE_B;
    assign is_erase = lq.opc == `FEPC_OP_SECTOR_ERASE
                      || lq.opc == `FEPC_OP_HALF_BLOCK
                      || lq.opc == `FEPC_OP_BLOCK_ERASE;

    // Opcode to operation kind
    always_comb begin
        if (lq.opc == `FEPC_OP_SECTOR_ERASE) begin
            kind = FEPC_K_SECTOR;
        end else if (lq.opc == `FEPC_OP_HALF_BLOCK) begin
            kind = FEPC_K_HALF;
        end else if (lq.opc == `FEPC_OP_BLOCK_ERASE) begin
            kind = FEPC_K_BLOCK;
        end else if (is_chip) begin
            kind = FEPC_K_CHIP;
        end else begin
            kind = FEPC_K_PAGE;
        end
    end

    // sectors, pages and blocks by enclosing block
    // chip erase needs every protect bit clear
    assign prot_hit = is_chip ? (I_PROTECT_SEL != 5'd0)
                              : prot_f(I_PROTECT_SEL, lq.addr[20:16]);

    // Sequencer next state
    always_comb begin
        d           = q;
        d.req.valid = 1'b0;
        d.rej       = 1'b0;
        // Chip select crosses through two flops, third finds the edge
        d.cs_s1 = I_CS_N;
        d.cs_s2 = q.cs_s1;
        d.cs_s3 = q.cs_s2;
        // Page buffer read port for the array core
        d.rd  = lq.buff[I_BUF_IDX];
        d.rdv = lq.mask[I_BUF_IDX];
        case (q.st)
            FEPC_ST_IDLE: begin
                if (!cs_rise) begin
                    // Wait for a frame
                end else if (lq.opc == `FEPC_OP_WRITE_UNLOCK) begin
                    if (ok_opc) begin
                        d.write_unlock_latch = 1'b1;
                    end else begin
                        d.rej = 1'b1;
                    end
                end else if (is_erase || is_chip
                             || lq.opc == `FEPC_OP_PAGE_WRITE) begin
                    // erase must end right after the address
                    // page write must end on a data byte edge
                    if ((is_erase && !ok_addr) || (is_chip && !ok_opc)
                        || (kind == FEPC_K_PAGE && !ok_page)) begin
                        d.rej = 1'b1;
                    end else if (!q.write_unlock_latch) begin
                        d.rej = 1'b1;
                    end else if (prot_hit) begin
                        d.rej = 1'b1;
                        // half block still drops the latch
                        if (kind == FEPC_K_HALF) begin
                            d.write_unlock_latch = 1'b0;
                        end
                    end else begin
                        d.st        = FEPC_ST_BUSY;
                        d.timer     = dur_f(kind);
                        d.req.valid = 1'b1;
                        d.req.kind  = kind;
                        // chip from zero, page by mask
                        case (kind)
                            FEPC_K_SECTOR:
                                d.req.addr = lq.addr & `FEPC_SECTOR_MASK;
                            FEPC_K_HALF:
                                d.req.addr = lq.addr & `FEPC_HALF_MASK;
                            FEPC_K_BLOCK:
                                d.req.addr = lq.addr & `FEPC_BLOCK_MASK;
                            FEPC_K_CHIP:
                                d.req.addr = 24'h00_0000;
                            default:
                                d.req.addr = lq.addr & `FEPC_PAGE_MASK;
                        endcase
                    end
                end
            end
            default: begin
                // hold busy, then drop busy and the latch together.
                // Frames that end while busy are dropped: the link
                // buffer belongs to the running program cycle.
                if (q.timer == 32'h0000_0000) begin
                    d.st  = FEPC_ST_IDLE;
                    d.write_unlock_latch = 1'b0;
                end else begin
                    d.timer = q.timer - 32'h0000_0001;
                end
            end
        endcase
    end

    // Sequencer state register; chip select idles high
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            q       <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.cs_s3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // These commands never drive the data lines
    assign O_SIO                = 4'h0;
    assign O_SIO_OE             = 4'h0;
    assign O_BUF_BYTE           = q.rd;
    assign O_BUF_VALID          = q.rdv;
    assign O_ARRAY_REQ          = q.req;
    assign O_OP_IN_PROGRESS     = q.st == FEPC_ST_BUSY;
    assign O_WRITE_UNLOCK_LATCH = q.write_unlock_latch;
    assign O_CMD_REJECT         = q.rej;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    a_start_needs_wel: assert property (
        q.req.valid |-> $past(q.write_unlock_latch))
        else $error("cycle started without write unlock");

    a_busy_at_start: assert property (
        q.req.valid |-> O_OP_IN_PROGRESS ##1 O_OP_IN_PROGRESS)
        else $error("busy flag missing at start");

    a_finish_clears: assert property (
        $fell(O_OP_IN_PROGRESS) |-> !O_WRITE_UNLOCK_LATCH)
        else $error("latch survived end of cycle");

    a_chip_unprot: assert property (
        q.req.valid && q.req.kind == FEPC_K_CHIP
        |-> $past(I_PROTECT_SEL) == 5'd0)
        else $error("chip erase under protection");

    a_prot_no_start: assert property (
        q.req.valid |-> !$past(prot_hit))
        else $error("protected region started");

    a_sector_align: assert property (
        q.req.valid && q.req.kind == FEPC_K_SECTOR
        |-> q.req.addr[11:0] == 12'h000)
        else $error("sector address not aligned");

    a_block_align: assert property (
        q.req.valid && q.req.kind == FEPC_K_BLOCK
        |-> q.req.addr[15:0] == 16'h0000)
        else $error("block address not aligned");

    a_half_prot_wel: assert property (
        cs_rise && q.st == FEPC_ST_IDLE && kind == FEPC_K_HALF
        && is_erase && ok_addr && q.write_unlock_latch && prot_hit
        |=> !q.write_unlock_latch && !q.req.valid && O_CMD_REJECT)
        else $error("protected half block mishandled");

    a_bad_frame: assert property (
        cs_rise && q.st == FEPC_ST_IDLE && is_erase && !ok_addr
        |=> !q.req.valid ##1 !O_OP_IN_PROGRESS)
        else $error("badly framed erase accepted");

    a_page_has_data: assert property (
        q.req.valid && q.req.kind == FEPC_K_PAGE
        |-> $past(lq.nbytes) != 9'd0)
        else $error("page write without data");

    c_sector_run: cover property (
        q.req.valid && q.req.kind == FEPC_K_SECTOR);
    c_page_run: cover property (
        q.req.valid && q.req.kind == FEPC_K_PAGE);
    c_chip_run: cover property (
        q.req.valid && q.req.kind == FEPC_K_CHIP);
    c_rejected: cover property (O_CMD_REJECT);

endmodule : fepc_top
`default_nettype wire

// >>> testbench/fepc_host_model.sv
// Host controller model that frames commands on the serial link
`default_nettype none
module fepc_host_model (
    output var logic       o_sck,
    output var logic       o_cs_n,
    output var logic [3:0] o_sio
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] junk; // Changing pattern for lines the device must ignore
    ////////////////////////////////////////////////////////////////////////
    // Idle link: clock still, deselected
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_sio  = 4'h5;
        junk   = 4'hA;
    end
    ////////////////////////////////////////////////////////////////////////
    // Send nbits of b, MSB first; a count off the byte edge breaks framing
    // frame bit count
    task automatic send_frame(input logic [7:0] b[$], input int nbits, input logic quad);
        int         k;
        logic [7:0] cur;
        o_cs_n = 1'b0;
        for (k = 0; k < nbits; k += (quad ? 4 : 1)) begin
            cur  = b[k / 8];
            junk = ~junk;
            if (quad) begin
                o_sio = (k % 8 == 0) ? cur[7:4] : cur[3:0];
            end else begin
                o_sio = {junk[3:1], cur[7 - (k % 8)]};
            end
            #62.5 o_sck = 1'b1;
            #62.5 o_sck = 1'b0;
        end
        // Deselect right after the last bit; stale data is never left behind
        #40 o_cs_n = 1'b1;
        o_sio = ~o_sio;
    endtask : send_frame
endmodule : fepc_host_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the erase and page program command block
`default_nettype none
module testbench import fepc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Short cycle counts keep the run brief
    localparam int SE = 20;
    localparam int HB = 30;
    localparam int BE = 40;
    localparam int CE = 50;
    localparam int PP = 10;
    logic       mclk;        // System clock
    logic       sys_rst;     // Asynchronous reset
    logic       quad_mode;   // Four-line command mode select
    logic [4:0] protect_sel; // Protect select bits
    logic [7:0] buf_idx;     // Page buffer read index
    wire logic  sck;         // Link clock from the host
    wire logic  cs_n;        // Chip select from the host
    logic [3:0] host_sio;    // Host data lines
    logic [3:0] dev_sio;     // Device data outputs
    logic [3:0] dev_oe;      // Device output enables
    wire logic [3:0] sio_w = (dev_oe & dev_sio) | (~dev_oe & host_sio); // Resolved lines
    logic [7:0] buf_byte;    // Buffer byte read back
    logic       buf_valid;   // Buffer byte was written
    fepc_req_s  req;         // Array request
    logic       busy;        // Operation in progress
    logic       latch;       // Write unlock latch
    logic       rej;         // Command rejected pulse
    int         miscompares; // Mismatches seen
    int         cmp_count;   // Comparisons made
    ////////////////////////////////////////////////////////////////////////
    fepc_top #(.SE_CYC(SE), .HB_CYC(HB), .BE_CYC(BE), .CE_CYC(CE), .PP_CYC(PP)) i_fepc_top (
        .I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_SCK(sck), .I_CS_N(cs_n), .I_SIO(sio_w),
        .O_SIO(dev_sio), .O_SIO_OE(dev_oe), .I_QUAD_MODE(quad_mode),
        .I_PROTECT_SEL(protect_sel), .I_BUF_IDX(buf_idx), .O_BUF_BYTE(buf_byte),
        .O_BUF_VALID(buf_valid), .O_ARRAY_REQ(req), .O_OP_IN_PROGRESS(busy),
        .O_WRITE_UNLOCK_LATCH(latch), .O_CMD_REJECT(rej));
    fepc_host_model i_fepc_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_sio(host_sio));
    ////////////////////////////////////////////////////////////////////////
    // Clock generator
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Wait a few cycles, on the falling edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    // Bounded wait for a request or a reject after a frame
    task automatic wait_end;
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge mclk);
            if (req.valid === 1'b1 || rej === 1'b1) begin
                return;
            end
        end
        miscompares++;
        finish_test();
    endtask : wait_end
    // Address-carrying command in the current line mode
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nbits);
        i_fepc_host_model.send_frame('{op, a[23:16], a[15:8], a[7:0], 8'h00}, nbits, quad_mode);
    endtask : cmd
    // Set the latch and see it appear
    task automatic unlock;
        i_fepc_host_model.send_frame('{8'h06}, 8, quad_mode);
        cyc(8);
        chk(latch, 1'b1);
    endtask : unlock
    // Expect an accepted operation and time its busy period
    task automatic exp_op(input fepc_kind_e kind, input logic [23:0] addr, input int len);
        int n;
        wait_end();
        chk(req.valid, 1'b1);
        chk(req.kind, kind);
        chk(req.addr, addr);
        chk(latch, 1'b1);
        for (n = 0; n < 1000 && busy === 1'b1; n++) begin
            @(negedge mclk);
        end
        chk(n, len);
        // A busy flag that never drops has used up the bound
        if (n == 1000) begin
            finish_test();
        end
        chk(latch, 1'b0);
        cyc(4);
    endtask : exp_op
    // Expect a reject with no array request
    task automatic exp_rej(input logic latch_exp);
        wait_end();
        chk(rej, 1'b1);
        chk({req.valid, busy}, 2'b00);
        cyc(4);
        chk(latch, latch_exp);
    endtask : exp_rej
    // Read one page buffer byte back
    task automatic rd(input logic [7:0] idx, input logic [7:0] b, input logic v);
        @(posedge mclk);
        buf_idx <= idx;
        @(posedge mclk);
        #1;
        chk({buf_valid, (v ? buf_byte : 8'h00)}, {v, b});
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // Erases with and without protection, latch and framing faults
    task automatic s_erase;
        unlock();
        cmd(8'h20, 24'h12_3456, 32);
        exp_op(FEPC_K_SECTOR, 24'h12_3000, SE);
        cmd(8'h20, 24'h00_1000, 32);
        exp_rej(1'b0);
        unlock();
        cmd(8'hD8, 24'h01_0000, 31);
        exp_rej(1'b1);
        cmd(8'hD8, 24'h05_ABCD, 32);
        exp_op(FEPC_K_BLOCK, 24'h05_0000, BE);
        unlock();
        cmd(8'h52, 24'h0A_BCDE, 32);
        exp_op(FEPC_K_HALF, 24'h0A_8000, HB);
        @(posedge mclk);
        protect_sel <= 5'h01;
        unlock();
        cmd(8'h52, 24'h1F_8123, 32);
        exp_rej(1'b0);
        unlock();
        cmd(8'h20, 24'h1F_0000, 32);
        exp_rej(1'b1);
        cmd(8'hD8, 24'h1F_FFFF, 32);
        exp_rej(1'b1);
        cmd(8'h60, 24'h00_0000, 8);
        exp_rej(1'b1);
        cmd(8'h02, 24'h1F_0000, 40);
        exp_rej(1'b1);
        cmd(8'h20, 24'h1E_F000, 32);
        exp_op(FEPC_K_SECTOR, 24'h1E_F000, SE);
        @(posedge mclk);
        protect_sel <= 5'h00;
        unlock();
        cmd(8'h60, 24'h00_0000, 8);
        exp_op(FEPC_K_CHIP, 24'h00_0000, CE);
        unlock();
        cmd(8'hC7, 24'h00_0000, 8);
        exp_op(FEPC_K_CHIP, 24'h00_0000, CE);
    endtask : s_erase
    // Page write wrap, short write, overlong write and framing faults
    task automatic s_page;
        logic [7:0] q[$];
        int         i;
        unlock();
        i_fepc_host_model.send_frame('{8'h02, 8'h00, 8'h12, 8'hFE, 8'hAA, 8'hBB, 8'hCC}, 56, 1'b0);
        exp_op(FEPC_K_PAGE, 24'h00_1200, PP);
        rd(8'hFE, 8'hAA, 1'b1);
        rd(8'h00, 8'hCC, 1'b1);
        rd(8'h01, 8'h00, 1'b0);
        unlock();
        cmd(8'h02, 24'h00_0000, 32);
        exp_rej(1'b1);
        i_fepc_host_model.send_frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 36, 1'b0);
        exp_rej(1'b1);
        q = '{8'h02, 8'h00, 8'h00, 8'h00};
        for (i = 0; i < 258; i++) begin
            q.push_back(i < 2 ? 8'hEE : i[7:0]);
        end
        i_fepc_host_model.send_frame(q, 8 * 262, 1'b0);
        exp_op(FEPC_K_PAGE, 24'h00_0000, PP);
        rd(8'h00, 8'h00, 1'b1);
        rd(8'h01, 8'h01, 1'b1);
    endtask : s_page
    // Block erase carried on four lines
    task automatic s_quad;
        @(posedge mclk);
        quad_mode <= 1'b1;
        // Unknown opcode frame lets the mode settle on the link side
        i_fepc_host_model.send_frame('{8'hFF, 8'hFF}, 16, 1'b1);
        cyc(8);
        unlock();
        cmd(8'hD8, 24'h0A_BCDE, 32);
        exp_op(FEPC_K_BLOCK, 24'h0A_0000, BE);
        @(posedge mclk);
        quad_mode <= 1'b0;
    endtask : s_quad
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        miscompares = 0;
        cmp_count   = 0;
        sys_rst     = 1'b1;
        quad_mode   = 1'b0;
        protect_sel = 5'h00;
        buf_idx     = 8'h00;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(4);
        chk({req, busy, latch, rej, buf_valid}, 32'h0000_0000);
        s_erase();
        s_page();
        s_quad();
        chk({dev_oe, dev_sio}, 32'h0000_0000);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
